// [hw/bsss_pkg.sv]
// Package with boot source codes, strap layout and timing counts
package bsss_pkg;
	localparam int SEL_W = 3;
	localparam int STRAP_W = 4;
	localparam int SYNC_STAGES = 2;
	// Nanoseconds of held reset-phase sampling before the capture is taken
	localparam int SETTLE_NS = 100;
	localparam int CLK_NS = 10;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// Strap bit positions
	localparam int STRAP_SPI_DO = 0;
	localparam int STRAP_AUDIO = 1;
	localparam int STRAP_AUD_CLK = 2;
	localparam int STRAP_AUD_LR = 3;
	localparam logic [3:0] STRAP_RESET = 4'h0;
	// Select codes as bits 2,1,0, 0 meaning grounded
	localparam logic [2:0] SEL_CAR_SPI = 3'h3;
	typedef enum logic [2:0] {
		BSSS_SRC_CAR_SATA = 3'b000,
		BSSS_SRC_CAR_SD = 3'b001,
		BSSS_SRC_CAR_ESPI = 3'b010,
		BSSS_SRC_CAR_SPI = 3'b011,
		BSSS_SRC_MOD_NAND = 3'b100,
		BSSS_SRC_REMOTE = 3'b101,
		BSSS_SRC_MOD_EMMC = 3'b110,
		BSSS_SRC_MOD_SPI = 3'b111
	} bsss_src_t;
	typedef enum logic [1:0] {
		BSSS_ST_RESET = 2'b00,
		BSSS_ST_SETTLE = 2'b01,
		BSSS_ST_LOCKED = 2'b10
	} bsss_state_t;
endpackage

// [hw/bsss_sync.sv]
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module bsss_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Levels
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1Reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage1Reg <= INIT;
			syncOut <= INIT;
		end else begin
			stage1Reg <= pinIn;
			syncOut <= stage1Reg;
		end
	end
endmodule
`default_nettype wire

// [hw/bsss_boot_select.sv]
// Boot source decode and reset-time strap capture
// How it works
// [RULE_01] Boot device chosen from three active-low selects; floating reads high.
// [RULE_02] Carrier drives selects and recovery only open-drain; module pull-up sets float.
// [RULE_03] Generic decode: eight codes map to carrier or module boot devices.
// [RULE_04] Carrier SPI chip select 0 only for code grounded, float, float.
// [RULE_05] Every other select code boots from on-module SPI flash.
// [RULE_06] Forced-recovery input is unsupported and takes no action.
// [RULE_07] Strap pins are inputs in reset, levels latched, then normal function resumes.
// [RULE_08] Carrier adds no loads or pulls that change strap levels.
// [RULE_09] Selects sampled once around reset; result held until next reset.
`timescale 1ns/1ns
`default_nettype none
module bsss_boot_select #(
	parameter int SETTLE = bsss_pkg::SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Carrier select and recovery pins
	input wire logic boot_select_bit0_n,
	input wire logic boot_select_bit1_n,
	input wire logic boot_select_bit2_n,
	input wire logic recovery_request_n,
	// Strap pins, input side
	input wire logic spiDataOutIn,
	input wire logic audio_codec_data_out_in,
	input wire logic audioClkIn,
	input wire logic audioLrClkIn,
	// Strap pins, functional drive from the chipset
	input wire logic spiDataOutFn,
	input wire logic audioDataOutFn,
	// Strap pins, drive and enable (enable low means driving)
	output logic spiDataOut,
	output logic spiDataOutOe_n,
	output logic audio_serial2_data_out,
	output logic audioDataOutOe_n,
	// Results
	output logic [2:0] genericSource,
	output logic bootCarrierSpi,
	output logic bootModuleSpi,
	output logic [3:0] strapLatched,
	output logic configLocked
);
	logic [6:0] pinSync;
	logic [2:0] selSync;
	logic [3:0] strapSync;
	bsss_pkg::bsss_state_t stateReg, stateNext;
	logic [7:0] cntReg, cntNext;
	logic [2:0] srcReg, srcNext;
	logic carSpiReg, carSpiNext;
	logic modSpiReg, modSpiNext;
	logic [3:0] strapReg, strapNext;
	logic lockReg, lockNext;
	// SETTLE within 2 to 256: below 2 the synchroniser is not yet full
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE - 1);

	// Pins are asynchronous to mclk; floating selects reset to high
	bsss_sync #(.WIDTH(7), .INIT(7'h07)) uSync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pinIn({audioLrClkIn, audioClkIn, audio_codec_data_out_in, spiDataOutIn,
			boot_select_bit2_n, boot_select_bit1_n, boot_select_bit0_n}),
		.syncOut(pinSync)
	);
	assign selSync = pinSync[2:0]; // RULE_01
	assign strapSync = pinSync[6:3];

	function automatic logic isCarrierSpi(input logic [2:0] sel);
		return sel == bsss_pkg::SEL_CAR_SPI; // RULE_04
	endfunction

	// Full generic table kept visible; only the carrier SPI code is acted on
	function automatic bsss_pkg::bsss_src_t decodeGeneric(input logic [2:0] sel);
		case (sel)
			3'h0: return bsss_pkg::BSSS_SRC_CAR_SATA;
			3'h1: return bsss_pkg::BSSS_SRC_CAR_SD;
			3'h2: return bsss_pkg::BSSS_SRC_CAR_ESPI;
			3'h3: return bsss_pkg::BSSS_SRC_CAR_SPI;
			3'h4: return bsss_pkg::BSSS_SRC_MOD_NAND;
			3'h5: return bsss_pkg::BSSS_SRC_REMOTE;
			3'h6: return bsss_pkg::BSSS_SRC_MOD_EMMC;
			3'h7: return bsss_pkg::BSSS_SRC_MOD_SPI;
			default: return bsss_pkg::BSSS_SRC_MOD_SPI;
		endcase
	endfunction

	// Recovery request deliberately unused: no path reads it
	logic unusedRecovery;
	assign unusedRecovery = recovery_request_n; // RULE_06

	always_comb begin
		stateNext = stateReg;
		cntNext = cntReg;
		srcNext = srcReg;
		carSpiNext = carSpiReg;
		modSpiNext = modSpiReg;
		strapNext = strapReg;
		lockNext = lockReg;
		case (stateReg)
			bsss_pkg::BSSS_ST_RESET: begin
				cntNext = 8'h00;
				stateNext = bsss_pkg::BSSS_ST_SETTLE;
			end
			bsss_pkg::BSSS_ST_SETTLE: begin
				// Wait lets the synchroniser fill before sampling
				if (cntReg >= SETTLE_LAST) begin
					srcNext = decodeGeneric(selSync); // RULE_03
					carSpiNext = isCarrierSpi(selSync); // RULE_04
					modSpiNext = !isCarrierSpi(selSync); // RULE_05
					strapNext = strapSync; // RULE_07
					lockNext = 1'b1; // RULE_09
					stateNext = bsss_pkg::BSSS_ST_LOCKED;
				end else begin
					cntNext = cntReg + 8'h01;
				end
			end
			bsss_pkg::BSSS_ST_LOCKED: begin
				// Held until next reset; later select changes ignored
				stateNext = bsss_pkg::BSSS_ST_LOCKED; // RULE_09
			end
			default: begin
				stateNext = bsss_pkg::BSSS_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stateReg <= bsss_pkg::BSSS_ST_RESET;
			cntReg <= 8'h00;
			srcReg <= bsss_pkg::BSSS_SRC_MOD_SPI;
			carSpiReg <= 1'b0;
			modSpiReg <= 1'b1;
			strapReg <= bsss_pkg::STRAP_RESET;
			lockReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			srcReg <= srcNext;
			carSpiReg <= carSpiNext;
			modSpiReg <= modSpiNext;
			strapReg <= strapNext;
			lockReg <= lockNext;
		end
	end

	// Strap pins stay released until capture, then resume normal duty
	// Data lags the enable by one edge, so a pin first drives low
	logic [1:0] fnDrive;
	logic [1:0] pinDrvReg, pinDrvNext;
	logic [1:0] pinOeNReg, pinOeNNext;
	assign fnDrive = {audioDataOutFn, spiDataOutFn};
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pinDrvNext[i] = lockReg & fnDrive[i]; // RULE_07
			pinOeNNext[i] = !lockNext; // RULE_07
		end
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinDrvReg <= 2'h0;
			pinOeNReg <= 2'h3;
		end else begin
			pinDrvReg <= pinDrvNext;
			pinOeNReg <= pinOeNNext;
		end
	end
	assign spiDataOut = pinDrvReg[bsss_pkg::STRAP_SPI_DO];
	assign audio_serial2_data_out = pinDrvReg[bsss_pkg::STRAP_AUDIO];
	assign spiDataOutOe_n = pinOeNReg[bsss_pkg::STRAP_SPI_DO];
	assign audioDataOutOe_n = pinOeNReg[bsss_pkg::STRAP_AUDIO];
	assign genericSource = srcReg;
	assign bootCarrierSpi = carSpiReg;
	assign bootModuleSpi = modSpiReg;
	assign strapLatched = strapReg;
	assign configLocked = lockReg;

	chk_lock_one_hot: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_05
		bootCarrierSpi != bootModuleSpi)
		else $error("Boot choice not exclusive");
	chk_carrier_spi_code: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_04
		configLocked |-> (bootCarrierSpi == (genericSource == bsss_pkg::SEL_CAR_SPI)))
		else $error("Carrier SPI decode wrong");
	chk_capture_time: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_03
		$rose(configLocked) |-> genericSource == $past(selSync))
		else $error("Capture does not match select");
	chk_hold_stable: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_09
		configLocked |=> configLocked && $stable(genericSource) && $stable(strapLatched))
		else $error("Locked choice changed");
	chk_strap_capture: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_07
		$rose(configLocked) |-> strapLatched == $past(strapSync))
		else $error("Strap capture wrong");
	chk_pin_release: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_07
		!configLocked |-> spiDataOutOe_n && audioDataOutOe_n && !spiDataOut
		&& !audio_serial2_data_out)
		else $error("Strap pin driven before capture");
	chk_lock_bound: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_09
		$fell(stateReg == bsss_pkg::BSSS_ST_RESET) |-> ##[1:300] configLocked)
		else $error("Lock too late");
	chk_sel_default: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_01
		!configLocked |-> bootModuleSpi && genericSource == bsss_pkg::BSSS_SRC_MOD_SPI)
		else $error("Pre-lock default wrong");
	chk_strap_default: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_07
		!configLocked |-> strapLatched == bsss_pkg::STRAP_RESET)
		else $error("Strap value shown before capture");
	chk_pin_drive_lock: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_07
		configLocked |-> !spiDataOutOe_n && !audioDataOutOe_n)
		else $error("Strap pin not driven after capture");
	chk_pin_follow_fn: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_07
		configLocked && $past(configLocked) |-> spiDataOut == $past(spiDataOutFn)
		&& audio_serial2_data_out == $past(audioDataOutFn))
		else $error("Strap pin does not follow its function");

	cov_car_spi: cover property (@(posedge mclk) disable iff (!arst_n) $rose(bootCarrierSpi));
	cov_mod_spi: cover property (@(posedge mclk) disable iff (!arst_n)
		$rose(configLocked) && bootModuleSpi);
	cov_sata: cover property (@(posedge mclk) disable iff (!arst_n)
		configLocked && genericSource == bsss_pkg::BSSS_SRC_CAR_SATA);
	cov_remote: cover property (@(posedge mclk) disable iff (!arst_n)
		configLocked && genericSource == bsss_pkg::BSSS_SRC_REMOTE);
	cov_pin_drive: cover property (@(posedge mclk) disable iff (!arst_n)
		configLocked && !spiDataOutOe_n && spiDataOut);
endmodule
`default_nettype wire

// [verification/bsss_carrier_model.sv]
// Carrier board model: open-drain selects and strap pin levels
`timescale 1ns/1ns
`default_nettype none
module bsss_carrier_model (
	// Carrier pull-low requests
	input wire logic [2:0] selLow,
	input wire logic recLow,
	// Module resistors and pin drive
	input wire logic [3:0] strapPull,
	input wire logic spiDrv,
	input wire logic spiOe_n,
	input wire logic audDrv,
	input wire logic audOe_n,
	// Pin levels
	output logic [2:0] selPin_n,
	output logic recPin_n,
	output logic [3:0] strapPin
);
	// Never driven high: the module pull-up sets the floating level
	assign selPin_n = ~selLow;
	assign recPin_n = ~recLow;
	// No carrier loads, so only module resistors or module drive set a strap
	assign strapPin = {strapPull[3:2], audOe_n ? strapPull[1] : audDrv,
		spiOe_n ? strapPull[0] : spiDrv};
endmodule
`default_nettype wire

// [verification/bsss_boot_select_bench.sv]
// Self-checking bench for boot select decode and strap capture
`timescale 1ns/1ns
`default_nettype none
module bsss_boot_select_bench;
	localparam int SETTLE = 3;
	logic mclk = 0;
	logic arst_n = 0;
	logic [2:0] selLow = '0;
	logic recLow = 0;
	logic [3:0] strapPull = '0;
	logic spiFn = 0;
	logic audFn = 0;
	logic [2:0] selPin_n;
	logic recPin_n;
	logic [3:0] strapPin;
	logic spiOut, spiOe_n, audOut, audOe_n, carSpi, modSpi, locked;
	logic [2:0] src;
	logic [3:0] straps;
	int errors = 0;
	int comparisons = 0;
	int seed = 76;
	int expSrc;
	int expStraps;
	always #5 mclk = ~mclk;
	bsss_carrier_model u_bsss_carrier_model (.selLow(selLow), .recLow(recLow),
		.strapPull(strapPull), .spiDrv(spiOut), .spiOe_n(spiOe_n), .audDrv(audOut),
		.audOe_n(audOe_n), .selPin_n(selPin_n), .recPin_n(recPin_n), .strapPin(strapPin));
	bsss_boot_select #(.SETTLE(SETTLE)) u_bsss_boot_select (.mclk(mclk), .arst_n(arst_n),
		.boot_select_bit0_n(selPin_n[0]), .boot_select_bit1_n(selPin_n[1]),
		.boot_select_bit2_n(selPin_n[2]), .recovery_request_n(recPin_n),
		.spiDataOutIn(strapPin[0]), .audio_codec_data_out_in(strapPin[1]),
		.audioClkIn(strapPin[2]), .audioLrClkIn(strapPin[3]), .spiDataOutFn(spiFn),
		.audioDataOutFn(audFn), .spiDataOut(spiOut), .spiDataOutOe_n(spiOe_n),
		.audio_serial2_data_out(audOut), .audioDataOutOe_n(audOe_n), .genericSource(src),
		.bootCarrierSpi(carSpi), .bootModuleSpi(modSpi), .strapLatched(straps),
		.configLocked(locked));
	task automatic cmp(input string name, input logic [3:0] exp, input logic [3:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_results();
		cmp("genericSource", expSrc[3:0], {1'b0, src});
		cmp("bootCarrierSpi", {3'h0, expSrc == 3}, {3'h0, carSpi});
		cmp("bootModuleSpi", {3'h0, expSrc != 3}, {3'h0, modSpi});
		cmp("strapLatched", expStraps[3:0], straps);
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge mclk);
		for (int c = 0; c < 8; c++) begin
			@(negedge mclk);
			arst_n = 0;
			selLow = ~c[2:0];
			recLow = 1'($random(seed));
			strapPull = 4'($random(seed));
			@(negedge mclk);
			cmp("lockedInReset", 4'h0, {3'h0, locked});
			cmp("spiOeInReset", 4'h1, {3'h0, spiOe_n});
			cmp("audOeInReset", 4'h1, {3'h0, audOe_n});
			cmp("pinDriveInReset", 4'h0, {2'h0, audOut, spiOut});
			cmp("srcInReset", 4'h7, {1'b0, src});
			cmp("bootInReset", 4'h1, {2'h0, carSpi, modSpi});
			cmp("strapInReset", 4'h0, straps);
			arst_n = 1;
			expSrc = c;
			expStraps = int'(strapPull);
			// Lock is due at the edge after SETTLE edges past release
			repeat (SETTLE) @(negedge mclk);
			cmp("lockedEarly", 4'h0, {3'h0, locked});
			cmp("pinOeEarly", 4'h3, {2'h0, audOe_n, spiOe_n});
			@(negedge mclk);
			cmp("lockedOnTime", 4'h1, {3'h0, locked});
			check_results();
			// Pins move after capture; results must not follow them
			selLow = 3'($random(seed));
			recLow = ~recLow;
			strapPull = 4'($random(seed));
			spiFn = 1'($random(seed));
			audFn = 1'($random(seed));
			repeat (3) @(negedge mclk);
			check_results();
			cmp("pinDrive", {2'h0, audFn, spiFn}, {2'h0, audOut, spiOut});
			cmp("pinOe", 4'h0, {2'h0, audOe_n, spiOe_n});
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
